/* File: logic/drsr_top.sv */
// result status bytes one to three and digital input register
// assumes: a command sequencer drives the event pulses, track numbers and push requests,
// and the host reads bytes through the data register port, one strobe per cycle
`timescale 1ns/1ns
`default_nettype none
module drsr_top #(
    parameter int DEPTH = drsr_pkg::STACK_DEPTH
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // register port
    input  wire logic [2:0]            addr,
    input  wire logic [7:0]            wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [7:0]            rdata,
    // command sequencer
    input  wire logic                  cmd_start,
    input  wire logic                  write_active,
    input  wire drsr_pkg::drsr_evt_t   evt,
    input  wire logic                  id_valid,
    input  wire logic [7:0]            id_track,
    input  wire logic [7:0]            cur_track,
    input  wire logic                  drive_select_hi,
    input  wire logic                  drive_select_lo,
    input  wire logic                  push_two,
    input  wire logic                  push_three,
    // drive pins
    input  wire drsr_pkg::drsr_drive_t drive,
    // status out
    output logic                       result_ready,
    output logic      [1:0]            rate_select
);
    localparam int LW = $clog2(DEPTH+1);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] bitv(input int pos, input logic v);
        bitv = {7'h00, v} << pos;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]           st1_r;
    logic [7:0]           st2_r;
    logic [1:0]           rate_r;
    logic                 mode_r;
    logic [7:0]           rdata_r;
    logic                 ready_r;
    drsr_pkg::drsr_push_t push_st_r;
    drsr_pkg::drsr_push_t push_st_nxt;

    // ----------------------------------------------------------------
    // pin senses
    // ----------------------------------------------------------------
    wire prot_on  = !drive.protect_input_n;
    wire track_zero_input_on  = !drive.track_zero_input_n;
    wire head_on  = !drive.head_select_output_n;
    wire media_changed = !drive.media_change_input_n;

    // ----------------------------------------------------------------
    // cylinder compare
    // ----------------------------------------------------------------
    wire wrong_cylinder_flag = id_valid && (id_track != cur_track);
    wire bad_cylinder_flag   = wrong_cylinder_flag && (id_track == drsr_pkg::BAD_TRACK);

    // ----------------------------------------------------------------
    // status byte one
    // ----------------------------------------------------------------
    wire id_or_data_crc_error = evt.id_crc_bad || evt.data_crc_bad;
    wire no_data_flag = evt.sector_missing || evt.id_unreadable
                        || evt.track_seq_missing;
    wire write_protected_flag = prot_on && write_active;
    wire absent_id_sync_flag  = evt.no_id_mark || evt.no_data_mark;

    // unlisted positions are never set, so they stay zero
    wire [7:0] s1_set = bitv(drsr_pkg::S1_EOT, evt.end_of_track)
                      | bitv(drsr_pkg::S1_CRC, id_or_data_crc_error)
                      | bitv(drsr_pkg::S1_OVR, evt.overrun)
                      | bitv(drsr_pkg::S1_NDATA, no_data_flag)
                      | bitv(drsr_pkg::S1_NWR, write_protected_flag)
                      | bitv(drsr_pkg::S1_MARK, absent_id_sync_flag);

    // ----------------------------------------------------------------
    // status byte two
    // ----------------------------------------------------------------
    wire control_mark_flag  = evt.deleted_in_normal || evt.normal_in_deleted;

    wire [7:0] s2_set = bitv(drsr_pkg::S2_CTL, control_mark_flag)
                      | bitv(drsr_pkg::S2_DCRC, evt.data_crc_bad)
                      | bitv(drsr_pkg::S2_WCYL, wrong_cylinder_flag)
                      | bitv(drsr_pkg::S2_SEQ, evt.scan_equal)
                      | bitv(drsr_pkg::S2_SNM, evt.scan_not_met)
                      | bitv(drsr_pkg::S2_BCYL, bad_cylinder_flag)
                      | bitv(drsr_pkg::S2_MDM, evt.no_data_mark);

    // a set in the clearing cycle survives the clear
    wire [7:0] st1_nxt = (cmd_start ? 8'h00 : st1_r) | s1_set;
    wire [7:0] st2_nxt = (cmd_start ? 8'h00 : st2_r) | s2_set;

    // ----------------------------------------------------------------
    // status byte three, built from live pins
    // ----------------------------------------------------------------
    wire [7:0] st3 = bitv(drsr_pkg::S3_WP, prot_on)
                   | bitv(drsr_pkg::S3_ONE_HI, 1'b1)
                   | bitv(drsr_pkg::S3_TRACK_ZERO_INPUT, track_zero_input_on)
                   | bitv(drsr_pkg::S3_ONE_LO, 1'b1)
                   | bitv(drsr_pkg::S3_HEAD, head_on)
                   | bitv(drsr_pkg::S3_DS_HI, drive_select_hi)
                   | bitv(drsr_pkg::S3_DS_LO, drive_select_lo);

    // ----------------------------------------------------------------
    // digital input register
    // ----------------------------------------------------------------
    wire       low_density_indicator = rate_r[1] ^ rate_r[0];
    wire [7:0] din_first  = bitv(drsr_pkg::DI_CHG, media_changed);
    wire [7:0] din_second = din_first
                          | bitv(drsr_pkg::DI_RATE_HI, rate_r[1])
                          | bitv(drsr_pkg::DI_RATE_LO, rate_r[0])
                          | bitv(drsr_pkg::DI_DEN, low_density_indicator);
    wire [7:0] din_sel = mode_r ? din_second : din_first;

    // ----------------------------------------------------------------
    // result queue
    // ----------------------------------------------------------------
    wire [7:0]    q_head;
    wire [LW-1:0] q_level;
    wire          in_second = (push_st_r == drsr_pkg::PUSH_SECOND);
    wire          q_push = push_two || push_three || in_second;
    // byte one goes first, byte two follows on the next enabled edge
    wire [7:0]    q_data = in_second ? st2_r : (push_two ? st1_nxt : st3);
    wire          q_pop  = rd && (addr == drsr_pkg::ADDR_DATA);

    always_comb begin
        push_st_nxt = push_st_r;
        case (push_st_r)
            drsr_pkg::PUSH_IDLE: begin
                if (push_two)
                    push_st_nxt = drsr_pkg::PUSH_SECOND;
            end
            drsr_pkg::PUSH_SECOND: begin
                push_st_nxt = drsr_pkg::PUSH_IDLE;
            end
            default: begin
                push_st_nxt = drsr_pkg::PUSH_IDLE;
            end
        endcase
    end

    drsr_result_stack #(
        .W     (8),
        .DEPTH (DEPTH)
    ) u_stack (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .push      (q_push),
        .push_data (q_data),
        .pop       (q_pop),
        .head      (q_head),
        .level     (q_level)
    );

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire       wr_rate = wr && ((addr == drsr_pkg::ADDR_RATE) || (addr == drsr_pkg::ADDR_DIGIN));
    wire       wr_mode = wr && (addr == drsr_pkg::ADDR_MODE);
    wire [7:0] q_out   = (q_level != '0) ? q_head : 8'h00;
    wire [7:0] rd_sel  = (addr == drsr_pkg::ADDR_DATA)  ? q_out :
                         (addr == drsr_pkg::ADDR_DIGIN) ? din_sel :
                         (addr == drsr_pkg::ADDR_MODE)  ? bitv(drsr_pkg::MODE_BIT, mode_r) :
                         8'h00;
    wire [7:0] rdata_nxt = rd ? rd_sel : 8'h00;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st1_r <= 8'h00;
            st2_r <= 8'h00;
        end else if (ce) begin
            st1_r <= st1_nxt;
            st2_r <= st2_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rate_r <= drsr_pkg::RATE_RST;
            mode_r <= drsr_pkg::MODE_RST;
        end else if (ce) begin
            if (wr_rate)
                rate_r <= wdata[1:0];
            if (wr_mode)
                mode_r <= wdata[drsr_pkg::MODE_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r   <= 8'h00;
            ready_r   <= 1'b0;
            push_st_r <= drsr_pkg::PUSH_IDLE;
        end else if (ce) begin
            rdata_r   <= rdata_nxt;
            ready_r   <= (q_level != '0);
            push_st_r <= push_st_nxt;
        end
    end

    assign rdata        = rdata_r;
    assign result_ready = ready_r;
    assign rate_select  = rate_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_two_pushes;
        ce && push_two && !push_three && q_level <= LW'(DEPTH - 2) && !q_pop ##1 ce && !q_pop;
    endsequence

    AST_EOT_SET: assert property (ce && evt.end_of_track |=> st1_r[drsr_pkg::S1_EOT])
        else $error("end of track flag not set");
    AST_CRC_SET: assert property (ce && evt.data_crc_bad
        |=> st1_r[drsr_pkg::S1_CRC] && st2_r[drsr_pkg::S2_DCRC])
        else $error("data crc flags not set together");
    AST_OVR_SET: assert property (ce && evt.overrun && !cmd_start ##1 ce && !cmd_start
        |=> st1_r[drsr_pkg::S1_OVR])
        else $error("overrun flag lost");
    AST_ZERO_BITS: assert property (!st1_r[3] && !st2_r[7])
        else $error("reserved status bit set");
    AST_PROT_SET: assert property (ce && prot_on && write_active |=> st1_r[drsr_pkg::S1_NWR])
        else $error("write protect flag not set");
    AST_BAD_CYL: assert property (ce && id_valid && id_track == drsr_pkg::BAD_TRACK
        && cur_track != drsr_pkg::BAD_TRACK |=> st2_r[drsr_pkg::S2_BCYL] && st2_r[drsr_pkg::S2_WCYL])
        else $error("bad cylinder not flagged");
    AST_CLEAR: assert property (ce && cmd_start && s1_set == 8'h00 |=> st1_r == 8'h00)
        else $error("status byte one not cleared");
    AST_DIN_CHG: assert property (ce && rd && addr == drsr_pkg::ADDR_DIGIN
        |=> rdata[drsr_pkg::DI_CHG] == !$past(drive.media_change_input_n))
        else $error("media change bit wrong");
    AST_DIN_DEN: assert property (ce && rd && addr == drsr_pkg::ADDR_DIGIN && mode_r
        |=> rdata[drsr_pkg::DI_DEN] == ($past(rate_r[1]) ^ $past(rate_r[0])))
        else $error("density bit wrong");
    AST_DIN_FIRST: assert property (ce && rd && addr == drsr_pkg::ADDR_DIGIN && !mode_r
        |=> rdata[6:0] == 7'h00)
        else $error("first mode reserved bits not zero");
    AST_ST3_ONES: assert property (st3[drsr_pkg::S3_ONE_HI] && st3[drsr_pkg::S3_ONE_LO] && !st3[7])
        else $error("byte three fixed bits wrong");
    AST_PUSH_TWO: assert property (s_two_pushes |=> q_level == $past(q_level, 2) + LW'(2))
        else $error("two result bytes not queued");

    // ----------------------------------------------------------------
    // event, pin byte and port checks
    // ----------------------------------------------------------------
    sequence s_push_three;
        ce && push_three && !push_two && !in_second && q_level == '0 && !q_pop;
    endsequence
    sequence s_read_data;
        ce && rd && addr == drsr_pkg::ADDR_DATA && q_level != '0;
    endsequence

    AST_IDCRC_SET: assert property (ce && evt.id_crc_bad |=> st1_r[drsr_pkg::S1_CRC])
        else $error("id crc flag not set");
    AST_NDATA_SET: assert property (ce && no_data_flag |=> st1_r[drsr_pkg::S1_NDATA])
        else $error("no data flag not set");
    AST_MARK_SET: assert property (ce && (evt.no_id_mark || evt.no_data_mark) |=> st1_r[drsr_pkg::S1_MARK])
        else $error("missing mark flag not set");
    AST_CTL_SET: assert property (ce && control_mark_flag |=> st2_r[drsr_pkg::S2_CTL])
        else $error("control mark flag not set");
    AST_WCYL_SET: assert property (ce && id_valid && id_track != cur_track |=> st2_r[drsr_pkg::S2_WCYL])
        else $error("wrong cylinder flag not set");
    AST_SEQ_SET: assert property (ce && evt.scan_equal |=> st2_r[drsr_pkg::S2_SEQ])
        else $error("scan equal flag not set");
    AST_SNM_SET: assert property (ce && evt.scan_not_met |=> st2_r[drsr_pkg::S2_SNM])
        else $error("scan not met flag not set");
    AST_MDM_SET: assert property (ce && evt.no_data_mark |=> st2_r[drsr_pkg::S2_MDM])
        else $error("missing data mark flag not set");
    AST_ST1_HOLD: assert property (ce && !cmd_start |=> (st1_r & $past(st1_r)) == $past(st1_r))
        else $error("status byte one flag lost");
    AST_ST2_HOLD: assert property (ce && !cmd_start |=> (st2_r & $past(st2_r)) == $past(st2_r))
        else $error("status byte two flag lost");
    AST_ST3_WP: assert property (s_push_three |=> q_head[drsr_pkg::S3_WP] == !$past(drive.protect_input_n))
        else $error("byte three protect bit wrong");
    AST_ST3_TRACK_ZERO_INPUT: assert property (s_push_three |=> q_head[drsr_pkg::S3_TRACK_ZERO_INPUT] == !$past(drive.track_zero_input_n))
        else $error("byte three track zero bit wrong");
    AST_ST3_HEAD: assert property (s_push_three |=> q_head[drsr_pkg::S3_HEAD] == !$past(drive.head_select_output_n))
        else $error("byte three head bit wrong");
    AST_ST3_DSEL: assert property (s_push_three |=> q_head[drsr_pkg::S3_DS_HI] == $past(drive_select_hi)
        && q_head[drsr_pkg::S3_DS_LO] == $past(drive_select_lo)) else $error("byte three drive select wrong");
    AST_POP_DATA: assert property (s_read_data |=> rdata == $past(q_head))
        else $error("data register did not show queue head");
    AST_POP_LEVEL: assert property (s_read_data && !push_two && !push_three && !in_second
        |=> q_level == $past(q_level) - 1'b1) else $error("queue level did not fall on read");
    AST_EMPTY_READ: assert property (ce && rd && addr == drsr_pkg::ADDR_DATA && q_level == '0 |=> rdata == 8'h00)
        else $error("empty queue read not zero");
    AST_RDATA_IDLE: assert property (ce && !rd |=> rdata == 8'h00)
        else $error("read data stands outside read cycle");
    AST_READY: assert property (ce && q_level != '0 |=> result_ready)
        else $error("result ready not raised");
    AST_RATE_WR: assert property (ce && wr && addr == drsr_pkg::ADDR_RATE |=> rate_select == $past(wdata[1:0]))
        else $error("rate write not taken");
    AST_CCR_WR: assert property (ce && wr && addr == drsr_pkg::ADDR_DIGIN |=> rate_select == $past(wdata[1:0]))
        else $error("config rate write not taken");
    AST_DIN_RATE: assert property (ce && rd && addr == drsr_pkg::ADDR_DIGIN && mode_r
        |=> rdata[drsr_pkg::DI_RATE_HI:drsr_pkg::DI_RATE_LO] == $past(rate_r)) else $error("rate bits wrong");

endmodule
`default_nettype wire

/* File: logic/drsr_pkg.sv */
// result-status and digital-input package: offsets, bit positions, carriers
// assumes: used by drsr_top and drsr_result_stack through drsr_pkg::name
`default_nettype none
package drsr_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_RATE  = 3'h4;
    localparam logic [2:0] ADDR_DATA  = 3'h5;
    localparam logic [2:0] ADDR_MODE  = 3'h6;
    localparam logic [2:0] ADDR_DIGIN = 3'h7;

    // ----------------------------------------------------------------
    // reset values and constants
    // ----------------------------------------------------------------
    localparam logic [1:0] RATE_RST   = 2'h2;
    localparam logic       MODE_RST   = 1'b0;
    localparam logic [7:0] BAD_TRACK  = 8'hff;
    localparam int         STACK_DEPTH = 4;
    localparam int         MODE_BIT   = 0;

    // ----------------------------------------------------------------
    // status byte one bit positions
    // ----------------------------------------------------------------
    localparam int S1_EOT   = 7;
    localparam int S1_CRC   = 6;
    localparam int S1_OVR   = 4;
    localparam int S1_NDATA = 2;
    localparam int S1_NWR   = 1;
    localparam int S1_MARK  = 0;

    // ----------------------------------------------------------------
    // status byte two bit positions
    // ----------------------------------------------------------------
    localparam int S2_CTL  = 6;
    localparam int S2_DCRC = 5;
    localparam int S2_WCYL = 4;
    localparam int S2_SEQ  = 3;
    localparam int S2_SNM  = 2;
    localparam int S2_BCYL = 1;
    localparam int S2_MDM  = 0;

    // ----------------------------------------------------------------
    // status byte three and digital input bit positions
    // ----------------------------------------------------------------
    localparam int S3_WP     = 6;
    localparam int S3_ONE_HI = 5;
    localparam int S3_TRACK_ZERO_INPUT   = 4;
    localparam int S3_ONE_LO = 3;
    localparam int S3_HEAD   = 2;
    localparam int S3_DS_HI  = 1;
    localparam int S3_DS_LO  = 0;
    localparam int DI_CHG    = 7;
    localparam int DI_RATE_HI = 2;
    localparam int DI_RATE_LO = 1;
    localparam int DI_DEN    = 0;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic end_of_track;
        logic id_crc_bad;
        logic data_crc_bad;
        logic overrun;
        logic sector_missing;
        logic id_unreadable;
        logic track_seq_missing;
        logic no_id_mark;
        logic no_data_mark;
        logic deleted_in_normal;
        logic normal_in_deleted;
        logic scan_equal;
        logic scan_not_met;
    } drsr_evt_t;

    typedef struct packed {
        logic protect_input_n;
        logic track_zero_input_n;
        logic head_select_output_n;
        logic media_change_input_n;
    } drsr_drive_t;

    typedef enum logic [0:0] {
        PUSH_IDLE,
        PUSH_SECOND
    } drsr_push_t;

endpackage
`default_nettype wire

/* File: logic/drsr_result_stack.sv */
// result byte queue presented one byte at a time on the data register
// assumes: DEPTH is a power of two; push beyond full and pop on empty are dropped
`timescale 1ns/1ns
`default_nettype none
module drsr_result_stack #(
    parameter int W     = 8,
    parameter int DEPTH = drsr_pkg::STACK_DEPTH
) (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    // fill side
    input  wire logic                         push,
    input  wire logic [W-1:0]                 push_data,
    // drain side
    input  wire logic                         pop,
    output logic      [W-1:0]                 head,
    output logic      [$clog2(DEPTH+1)-1:0]   level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [LW-1:0] lvl_r;

    wire do_push = push && (lvl_r != LW'(DEPTH));
    wire do_pop  = pop && (lvl_r != '0);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            lvl_r <= '0;
        end else if (ce) begin
            if (do_push)
                wp_r <= wp_r + 1'b1;
            if (do_pop)
                rp_r <= rp_r + 1'b1;
            lvl_r <= lvl_r + LW'(do_push) - LW'(do_pop);
        end
    end

    always_ff @(posedge mclk) begin
        if (ce && do_push)
            mem[wp_r] <= push_data;
    end

    assign head  = mem[rp_r];
    assign level = lvl_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_STACK_FILL: assert property (ce && push && !pop && level < LW'(DEPTH) |=> level == $past(level) + 1'b1)
        else $error("queue level did not rise on push");

endmodule
`default_nettype wire

/* File: dv/drsr_host.sv */
// host model: register port master for the result status block
// assumes: one master, strobes launched by nba right after a rising edge
`timescale 1ns/1ns
`default_nettype none
module drsr_host (
    // clock
    input  wire logic       mclk,
    // register port
    output logic      [2:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd,
    input  wire logic [7:0] rdata
);
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    initial begin
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    task automatic put(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic get(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
endmodule
`default_nettype wire

/* File: dv/test_diskette_result_status_regs.sv */
// testbench for the result status and digital input block
// assumes: drsr_host drives the register port; clock enable held high
`timescale 1ns/1ns
`default_nettype none
module test_diskette_result_status_regs;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                  mclk;
    logic                  rst_n;
    wire logic [2:0]       addr;
    wire logic [7:0]       wdata;
    wire logic             wr;
    wire logic             rd;
    logic      [7:0]       rdata, id_track, cur_track, d;
    logic                  cmd_start, write_active, id_valid, push_two, push_three, result_ready;
    logic      [1:0]       rate_select, ds, rt;
    logic      [3:0]       b;
    drsr_pkg::drsr_evt_t   evt;
    drsr_pkg::drsr_drive_t drive;
    int                    num_errors, num_checks;
    logic      [15:0]      tbl [13] = '{16'h8000, 16'h4000, 16'h4020, 16'h1000, 16'h0400, 16'h0400,
        16'h0400, 16'h0100, 16'h0101, 16'h0040, 16'h0040, 16'h0008, 16'h0004};

    drsr_host host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    drsr_top dut (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cmd_start(cmd_start), .write_active(write_active), .evt(evt), .id_valid(id_valid),
        .id_track(id_track), .cur_track(cur_track), .drive_select_hi(ds[1]), .drive_select_lo(ds[0]),
        .push_two(push_two), .push_three(push_three), .drive(drive), .result_ready(result_ready),
        .rate_select(rate_select));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic drain(input logic two, input logic [7:0] e1, input logic [7:0] e2);
        @(posedge mclk);
        push_two <= two;
        push_three <= ~two;
        @(posedge mclk);
        push_two <= 1'b0;
        push_three <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("ready", {7'h0, result_ready}, 8'h01);
        host.get(drsr_pkg::ADDR_DATA, d);
        chk("first byte", d, e1);
        if (two) begin
            host.get(drsr_pkg::ADDR_DATA, d);
            chk("second byte", d, e2);
        end
        host.get(drsr_pkg::ADDR_DATA, d);
        chk("empty queue", d, 8'h00);
    endtask

    task automatic stim(input logic [12:0] e, input logic wa, input logic iv, input logic [7:0] it,
                        input logic [15:0] x);
        @(posedge mclk);
        cmd_start <= 1'b1;
        @(posedge mclk);
        cmd_start <= 1'b0;
        evt <= e;
        write_active <= wa;
        id_valid <= iv;
        id_track <= it;
        @(posedge mclk);
        evt <= '0;
        write_active <= 1'b0;
        id_valid <= 1'b0;
        drain(1'b1, x[15:8], x[7:0]);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        #1000000;
        num_errors++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        {cmd_start, write_active, id_valid, push_two, push_three} = 5'h00;
        evt = '0;
        id_track = 8'h00;
        cur_track = 8'h05;
        ds = 2'h0;
        drive = '1;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk("rate reset", {6'h0, rate_select}, 8'h02);
        for (int i = 0; i < 13; i++) begin
            stim(13'h1 << (12 - i), 1'b0, 1'b0, 8'h00, tbl[i]);
        end
        stim('0, 1'b1, 1'b0, 8'h00, 16'h0000);
        drive <= 4'h7;
        stim('0, 1'b1, 1'b0, 8'h00, 16'h0200);
        stim('0, 1'b0, 1'b1, 8'h06, 16'h0010);
        stim('0, 1'b0, 1'b1, 8'hff, 16'h0012);
        stim('0, 1'b0, 1'b1, 8'h05, 16'h0000);
        $display("test status bytes done");
        for (int i = 0; i < 16; i++) begin
            b = 4'(i);
            drive <= b;
            ds <= b[2:1];
            drain(1'b0, {1'b0, ~b[3], 1'b1, ~b[2], 1'b1, ~b[1], b[2:1]}, 8'h00);
            host.get(drsr_pkg::ADDR_DIGIN, d);
            chk("input first mode", d, {~b[0], 7'h00});
        end
        $display("test pin byte done");
        host.put(drsr_pkg::ADDR_MODE, 8'h01);
        host.get(drsr_pkg::ADDR_MODE, d);
        chk("mode", d, 8'h01);
        drive <= 4'he;
        for (int r = 0; r < 4; r++) begin
            rt = 2'(r);
            host.put(rt[0] ? drsr_pkg::ADDR_DIGIN : drsr_pkg::ADDR_RATE, {6'h3f, rt});
            #1 chk("rate", {6'h0, rate_select}, {6'h0, rt});
            host.get(drsr_pkg::ADDR_DIGIN, d);
            chk("input second mode", d, {1'b1, 4'h0, rt, rt[1] ^ rt[0]});
        end
        host.put(3'h0, 8'h00);
        #1 chk("rate kept", {6'h0, rate_select}, 8'h03);
        host.get(drsr_pkg::ADDR_RATE, d);
        chk("rate read", d, 8'h00);
        host.get(3'h0, d);
        chk("unmapped", d, 8'h00);
        host.put(drsr_pkg::ADDR_MODE, 8'h00);
        host.get(drsr_pkg::ADDR_DIGIN, d);
        chk("input back to first", d, 8'h80);
        $display("test input register done");
        close_out();
    end
endmodule
`default_nettype wire
